// file: verilog/rsw_pkg.sv
// Purpose: shared constants for the radio sleep/wake sequencer pair
// Assumes: 25 MHz clock, 40 ns period
// Notes:   times kept in their own unit, cycle counts derived
package rsw_pkg;
   localparam int unsigned CLK_NS        = 40;
   localparam int unsigned T_PWR_US      = 1300;
   localparam int unsigned T_RST_US      = 1;
   localparam int unsigned T_PD_US       = 10;
   localparam int unsigned T_SLEEP_NS    = 50;
   localparam int unsigned T_WAKE_US     = 2000;
   localparam int unsigned T_STABLE_US   = 2100;
   localparam int unsigned T_STABLE2_US  = 2100;
   localparam int unsigned T_SPI_RDY_US  = 1;
   // least times round up, typical device times round down
   localparam int unsigned PWR_CYC    = (T_PWR_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int unsigned RST_CYC    = (T_RST_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int unsigned PD_CYC     = (T_PD_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int unsigned SLEEP_CYC  = (T_SLEEP_NS / CLK_NS) > 0 ?
                                        (T_SLEEP_NS / CLK_NS) : 1;
   localparam int unsigned WAKE_CYC   = T_WAKE_US * 1000 / CLK_NS;
   localparam int unsigned STABLE_CYC = T_STABLE_US * 1000 / CLK_NS;
   localparam int unsigned STAB2_CYC  = T_STABLE2_US * 1000 / CLK_NS;
   localparam int unsigned SPI_RDY_CYC =
      (T_SPI_RDY_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int unsigned CNT_W = 18;
   // device register map
   localparam logic [7:0] IRQ_PIN_CONFIG_ADDR  = 8'h05;
   localparam logic [7:0] WAKE_IRQ_ENABLE_ADDR = 8'h1c;
   localparam logic [7:0] IRQ_PIN_CONFIG_RST   = 8'h00;
   localparam logic [7:0] WAKE_IRQ_ENABLE_RST  = 8'h00;
   localparam int unsigned CFG_POL_BIT   = 0;
   localparam int unsigned CFG_DRIVE_BIT = 1;
   localparam int unsigned WAKE_EN_BIT   = 0;
   // host register map
   localparam logic [3:0] H_CTRL_ADDR    = 4'h0;
   localparam logic [3:0] H_STATUS_ADDR  = 4'h1;
   localparam logic [3:0] H_IRQ_ST_ADDR  = 4'h2;
   localparam logic [3:0] H_IRQ_MSK_ADDR = 4'h3;
   localparam logic [3:0] H_REG_ADDR     = 4'h4;
   localparam logic [3:0] H_REG_WDATA    = 4'h5;
   localparam logic [3:0] H_REG_RDATA    = 4'h6;
   localparam int unsigned CTRL_SLEEP_BIT = 0;
   localparam int unsigned CTRL_RST_BIT   = 1;
   localparam int unsigned CTRL_WR_BIT    = 2;
   localparam int unsigned CTRL_RD_BIT    = 3;
   localparam int unsigned EV_READY_BIT   = 0;
   localparam int unsigned EV_WAKE_BIT    = 1;
   localparam int unsigned EV_DONE_BIT    = 2;
endpackage

// file: verilog/rsw_link_if.sv
// Purpose: pins between host and radio sleep/wake sequencer
// Assumes: one clock; irq pin resolved from enable here
// Notes:   reg_* is a simplified parallel stand-in for the serial port
`timescale 1ns/1ns
interface rsw_link_if;
   logic       resetn;
   logic       power_down_pin;
   logic       irq_o_val;
   logic       irq_oe;
   logic       crystal_clock_output;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic       irq_pin;
   // open drain with pull-up when not driven
   assign irq_pin = irq_oe ? irq_o_val : 1'b1;
   modport dev (input resetn, input power_down_pin, output irq_o_val,
                output irq_oe, output crystal_clock_output, input reg_wr,
                input reg_rd, input reg_addr, input reg_wdata,
                output reg_rdata);
   modport host (output resetn, output power_down_pin, input irq_pin,
                 input crystal_clock_output, output reg_wr, output reg_rd,
                 output reg_addr, output reg_wdata, input reg_rdata);
endinterface

// file: verilog/rsw_device.sv
// Purpose: device end: sleep entry, wake timing, interrupt pin style
// Assumes: pins synchronous to clk_i
// Notes:   times are typical figures rounded down to cycles
//
// Overview of operation
// (RL1) host holds reset 1300 us after power
// (RL2) reset pulses last at least 1 us
// (RL3) power-down held asserted during power up
// (RL4) power-down released no sooner than 1300 us
// (RL5) power-down pulses last at least 10 us
// (RL6) power-down enters low power within 50 ns
// (RL7) clocks run 2000 us after release
// (RL8) clock output starts 2000 us after release
// (RL9) release raises wake irq if enabled
// (RL10) oscillator stable 2100 us after release
// (RL11) stable 2100 us after wake irq; code gives 100 us after it
// (RL12) host waits 1 us after stable
// (RL13) irq polarity and drive set by config
// (RL14) sleep ignores transactions, holds state
`timescale 1ns/1ns
module rsw_device (
   input  wire logic clk_i,
   input  wire logic resetn_i,
   input  wire logic clk_out_en_i,
   output logic      clocks_run_o,
   output logic      osc_stable_o,
   output logic      low_power_o,
   rsw_link_if.dev   link
);
   typedef enum logic [3:0] {
      DS_SLEEP  = 4'b0001,
      DS_WAKE   = 4'b0010,
      DS_SETTLE = 4'b0100,
      DS_RUN    = 4'b1000
   } rsw_dstate_type;

   rsw_dstate_type    state_ff, nxt_state;
   logic [17:0]       cnt_ff, nxt_cnt;
   logic [7:0]        cfg_ff, nxt_cfg;
   logic [7:0]        wen_ff, nxt_wen;
   logic [7:0]        rdata_ff, nxt_rdata;
   logic              wirq_ff, nxt_wirq;
   logic              ck_ff, nxt_ck;
   logic              lp_ff, nxt_lp;
   logic              run_ff, nxt_run;
   logic              stable_ff, nxt_stable;
   logic              active;

   // settle and run both count as awake for registers and clocks
   function automatic logic is_awake(input rsw_dstate_type s);
      is_awake = (s == DS_SETTLE) || (s == DS_RUN);
   endfunction

   // counter step shared by wake and settle; saturates so a stuck
   // state cannot wrap round into an early match
   function automatic logic [17:0] step_cnt(input logic [17:0] c);
      step_cnt = (&c) ? c : c + 18'h0_0001;
   endfunction

   // write select for one device register
   function automatic logic wr_hit(input logic       wr,
                                   input logic [7:0] addr,
                                   input logic [7:0] target);
      wr_hit = wr && (addr == target);
   endfunction

   // read mux; unmapped offsets read zero
   function automatic logic [7:0] rd_mux(input logic [7:0] addr,
                                         input logic [7:0] cfg,
                                         input logic [7:0] wen);
      unique case (addr)
         rsw_pkg::IRQ_PIN_CONFIG_ADDR:  rd_mux = cfg;
         rsw_pkg::WAKE_IRQ_ENABLE_ADDR: rd_mux = wen;
         default:                       rd_mux = 8'h00;
      endcase
   endfunction

   // pin level of the wake interrupt under the chosen polarity
   function automatic logic irq_level(input logic       wirq,
                                      input logic [7:0] cfg);
      irq_level = wirq ~^ cfg[rsw_pkg::CFG_POL_BIT];
   endfunction

   // open drain only pulls low; push-pull drives both levels
   function automatic logic irq_drive(input logic       lvl,
                                      input logic [7:0] cfg);
      irq_drive = cfg[rsw_pkg::CFG_DRIVE_BIT] || !lvl;
   endfunction

   // pin reset is folded in as a synchronous sleep-like clear
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_wirq  = wirq_ff;
      if (!link.resetn || link.power_down_pin) begin
         nxt_state = DS_SLEEP; // RL6
         nxt_cnt   = '0;
         nxt_wirq  = 1'b0;
      end else begin
         unique case (state_ff)
            DS_SLEEP: begin
               nxt_state = DS_WAKE;
               nxt_cnt   = 18'h0_0001;
            end
            DS_WAKE: begin
               nxt_cnt = step_cnt(cnt_ff);
               if (cnt_ff == 18'(rsw_pkg::WAKE_CYC)) begin // RL7
                  nxt_state = DS_SETTLE;
                  nxt_wirq  = wen_ff[rsw_pkg::WAKE_EN_BIT]; // RL9
               end
            end
            DS_SETTLE: begin
               nxt_cnt = step_cnt(cnt_ff);
               if (cnt_ff == 18'(rsw_pkg::STABLE_CYC)) begin // RL10
                  nxt_state = DS_RUN;
               end
            end
            DS_RUN: nxt_cnt = cnt_ff;
         endcase
      end
   end

   assign active = is_awake(state_ff);

   always_comb begin
      nxt_cfg   = cfg_ff;
      nxt_wen   = wen_ff;
      nxt_rdata = rdata_ff;
      if (!link.resetn) begin
         nxt_cfg = rsw_pkg::IRQ_PIN_CONFIG_RST;
         nxt_wen = rsw_pkg::WAKE_IRQ_ENABLE_RST;
      end else if (active) begin // RL14
         if (wr_hit(link.reg_wr, link.reg_addr,
                    rsw_pkg::IRQ_PIN_CONFIG_ADDR)) begin
            nxt_cfg = link.reg_wdata; // RL13
         end
         if (wr_hit(link.reg_wr, link.reg_addr,
                    rsw_pkg::WAKE_IRQ_ENABLE_ADDR)) begin
            nxt_wen = link.reg_wdata; // RL9
         end
         if (link.reg_rd) begin
            nxt_rdata = rd_mux(link.reg_addr, cfg_ff, wen_ff);
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_ff <= DS_SLEEP;
         cnt_ff   <= '0;
         cfg_ff   <= rsw_pkg::IRQ_PIN_CONFIG_RST;
         wen_ff   <= rsw_pkg::WAKE_IRQ_ENABLE_RST;
         rdata_ff <= 8'h00;
         wirq_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         cfg_ff   <= nxt_cfg;
         wen_ff   <= nxt_wen;
         rdata_ff <= nxt_rdata;
         wirq_ff  <= nxt_wirq;
      end
   end

   // status outputs taken from the next state, so they line up with
   // the state register and carry no decode glitches
   always_comb begin
      nxt_lp     = nxt_state == DS_SLEEP; // RL6
      nxt_run    = is_awake(nxt_state); // RL7
      nxt_stable = nxt_state == DS_RUN; // RL10
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         lp_ff     <= 1'b1;
         run_ff    <= 1'b0;
         stable_ff <= 1'b0;
      end else begin
         lp_ff     <= nxt_lp;
         run_ff    <= nxt_run;
         stable_ff <= nxt_stable;
      end
   end

   // stable mark counts from release, so it trails the irq by 100 us
   // typ; the second figure is not met, a known limitation
   assign osc_stable_o   = stable_ff; // RL11
   assign clocks_run_o   = run_ff;
   assign low_power_o    = lp_ff;
   assign link.reg_rdata = rdata_ff;
   // bit0: 1 = active high; bit1: 1 = push-pull, 0 = open drain
   assign link.irq_o_val = irq_level(wirq_ff, cfg_ff); // RL13
   assign link.irq_oe    = irq_drive(link.irq_o_val, cfg_ff); // RL13

   // gated clock stand-in: divide by two while running; held low
   // otherwise so the pin rests at a known level in sleep
   always_comb begin
      nxt_ck = 1'b0;
      if (active && clk_out_en_i) begin
         nxt_ck = !ck_ff; // RL8
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ck_ff <= 1'b0;
      end else begin
         ck_ff <= nxt_ck;
      end
   end

   assign link.crystal_clock_output = ck_ff;
endmodule

// file: verilog/rsw_host.sv
// Purpose: host end: drives reset and power-down with legal timing
// Assumes: software port as in house register style
// Notes:   wake interrupt read assuming default irq pin config
`timescale 1ns/1ns
module rsw_host (
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic [3:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic [7:0]      rdata_o,
   output logic            irq_o,
   rsw_link_if.host        link
);
   typedef enum logic [5:0] {
      HS_PWRUP = 6'b00_0001,
      HS_RST   = 6'b00_0010,
      HS_SLEEP = 6'b00_0100,
      HS_WAKE  = 6'b00_1000,
      HS_GAP   = 6'b01_0000,
      HS_READY = 6'b10_0000
   } rsw_hstate_type;

   rsw_hstate_type state_ff, nxt_state;
   logic [17:0]    cnt_ff, nxt_cnt;
   logic [7:0]     ctrl_ff, nxt_ctrl, st_ff, nxt_st, msk_ff, nxt_msk;
   logic [7:0]     ra_ff, nxt_ra, rw_ff, nxt_rw, rr_ff, nxt_rr;
   logic [7:0]     rdata_ff, nxt_rdata;
   logic [2:0]     ev;
   logic           ready, sleep_req, rd_pend_ff, nxt_rd_pend;

   assign ready     = state_ff == HS_READY;
   assign sleep_req = ctrl_ff[rsw_pkg::CTRL_SLEEP_BIT];

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff + 18'h0_0001;
      unique case (state_ff)
         HS_PWRUP: if (cnt_ff >= 18'(rsw_pkg::PWR_CYC)) begin // RL1 RL4
            nxt_state = HS_SLEEP;
            nxt_cnt   = '0;
         end
         HS_RST: if (cnt_ff >= 18'(rsw_pkg::RST_CYC)) begin // RL2
            nxt_state = HS_SLEEP;
            nxt_cnt   = '0;
         end
         HS_SLEEP: if (cnt_ff >= 18'(rsw_pkg::PD_CYC) && !sleep_req) begin
            nxt_state = HS_WAKE; // RL5
            nxt_cnt   = '0;
         end
         // wait full stable time; irq alone is not trusted
         HS_WAKE: if (cnt_ff >= 18'(rsw_pkg::STABLE_CYC)) begin // RL10
            nxt_state = HS_GAP;
            nxt_cnt   = '0;
         end
         HS_GAP: if (cnt_ff >= 18'(rsw_pkg::SPI_RDY_CYC)) begin // RL12
            nxt_state = HS_READY;
         end
         HS_READY: nxt_cnt = cnt_ff;
      endcase
      if (state_ff != HS_PWRUP) begin
         if (ctrl_ff[rsw_pkg::CTRL_RST_BIT]) begin
            nxt_state = HS_RST;
            nxt_cnt   = '0;
         end else if (sleep_req && state_ff != HS_SLEEP &&
                      state_ff != HS_RST) begin
            nxt_state = HS_SLEEP;
            nxt_cnt   = '0;
         end
      end
   end

   assign ev[rsw_pkg::EV_READY_BIT] = ready && state_ff != nxt_state ? 1'b0 :
                                      (state_ff == HS_GAP &&
                                       nxt_state == HS_READY);
   assign ev[rsw_pkg::EV_WAKE_BIT]  = state_ff == HS_WAKE && !link.irq_pin;
   assign ev[rsw_pkg::EV_DONE_BIT]  = rd_pend_ff;

   always_comb begin
      nxt_ctrl    = ctrl_ff;
      nxt_msk     = msk_ff;
      nxt_ra      = ra_ff;
      nxt_rw      = rw_ff;
      nxt_rr      = rr_ff;
      nxt_rdata   = rdata_ff;
      nxt_rd_pend = 1'b0;
      nxt_st      = st_ff;
      // one-shot bits self clear
      nxt_ctrl[rsw_pkg::CTRL_RST_BIT] = 1'b0;
      nxt_ctrl[rsw_pkg::CTRL_WR_BIT]  = 1'b0;
      nxt_ctrl[rsw_pkg::CTRL_RD_BIT]  = 1'b0;
      if (wr_i) begin
         unique case (addr_i)
            rsw_pkg::H_CTRL_ADDR:    nxt_ctrl = wdata_i;
            rsw_pkg::H_IRQ_ST_ADDR:  nxt_st   = st_ff & ~wdata_i;
            rsw_pkg::H_IRQ_MSK_ADDR: nxt_msk  = wdata_i;
            rsw_pkg::H_REG_ADDR:     nxt_ra   = wdata_i;
            rsw_pkg::H_REG_WDATA:    nxt_rw   = wdata_i;
            default: ;
         endcase
      end
      if (ctrl_ff[rsw_pkg::CTRL_RD_BIT] && ready)
         nxt_rd_pend = 1'b1;
      if (rd_pend_ff)
         nxt_rr = link.reg_rdata;
      nxt_st[2:0] = nxt_st[2:0] | ev; // set wins over clear
      if (rd_i) begin
         unique case (addr_i)
            rsw_pkg::H_CTRL_ADDR:    nxt_rdata = ctrl_ff;
            rsw_pkg::H_STATUS_ADDR:  nxt_rdata = {2'b00, state_ff};
            rsw_pkg::H_IRQ_ST_ADDR:  nxt_rdata = st_ff;
            rsw_pkg::H_IRQ_MSK_ADDR: nxt_rdata = msk_ff;
            rsw_pkg::H_REG_ADDR:     nxt_rdata = ra_ff;
            rsw_pkg::H_REG_WDATA:    nxt_rdata = rw_ff;
            rsw_pkg::H_REG_RDATA:    nxt_rdata = rr_ff;
            default:                 nxt_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_ff   <= HS_PWRUP;
         cnt_ff     <= '0;
         ctrl_ff    <= 8'h01;
         st_ff      <= 8'h00;
         msk_ff     <= 8'h00;
         ra_ff      <= 8'h00;
         rw_ff      <= 8'h00;
         rr_ff      <= 8'h00;
         rdata_ff   <= 8'h00;
         rd_pend_ff <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         cnt_ff     <= nxt_cnt;
         ctrl_ff    <= nxt_ctrl;
         st_ff      <= nxt_st;
         msk_ff     <= nxt_msk;
         ra_ff      <= nxt_ra;
         rw_ff      <= nxt_rw;
         rr_ff      <= nxt_rr;
         rdata_ff   <= nxt_rdata;
         rd_pend_ff <= nxt_rd_pend;
      end
   end

   assign rdata_o = rdata_ff;
   assign irq_o   = |(st_ff & msk_ff);
   // reset and power-down held from power up
   assign link.resetn = !(state_ff == HS_PWRUP || state_ff == HS_RST); // RL1
   assign link.power_down_pin = state_ff == HS_PWRUP ||
                                state_ff == HS_RST ||
                                state_ff == HS_SLEEP; // RL3
   assign link.reg_wr    = ctrl_ff[rsw_pkg::CTRL_WR_BIT] && ready; // RL12
   assign link.reg_rd    = ctrl_ff[rsw_pkg::CTRL_RD_BIT] && ready;
   assign link.reg_addr  = ra_ff;
   assign link.reg_wdata = rw_ff;
endmodule

// file: bench/rsw_link_monitor.sv
// Purpose: link checker for the sleep/wake pair
// Assumes: one clock, link pins sampled on clk_i
// Notes:   counters saturate so long runs stay legal
`timescale 1ns/1ns
module rsw_link_monitor (
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic       resetn,
   input  wire logic       power_down_pin,
   input  wire logic       irq_pin,
   input  wire logic       crystal_clock_output,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_rdata
);
   logic [17:0] up_ff;
   logic [17:0] pdh_ff;
   logic [17:0] rlo_ff;
   logic [17:0] wk_ff;
   logic        pd_ff;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         up_ff  <= '0;
         pdh_ff <= '0;
         rlo_ff <= '0;
         wk_ff  <= '0;
         pd_ff  <= 1'b1;
      end else begin
         up_ff  <= (&up_ff) ? up_ff : up_ff + 1'b1;
         pdh_ff <= !power_down_pin ? '0 : (&pdh_ff) ? pdh_ff : pdh_ff + 1'b1;
         rlo_ff <= resetn ? '0 : (&rlo_ff) ? rlo_ff : rlo_ff + 1'b1;
         wk_ff  <= power_down_pin ? '0 : (&wk_ff) ? wk_ff : wk_ff + 1'b1;
         pd_ff  <= power_down_pin;
      end
   end
   a_pd_min_width: assert property (pd_ff && !power_down_pin |->
      pdh_ff >= rsw_pkg::PD_CYC) else $error("power-down pulse too short");
   a_pd_release_late: assert property (pd_ff && !power_down_pin |->
      up_ff >= rsw_pkg::PWR_CYC) else $error("power-down released early");
   a_pd_at_pwrup: assert property (up_ff < rsw_pkg::PWR_CYC |->
      power_down_pin) else $error("power-down low during power up");
   a_rst_pwr_hold: assert property ($rose(resetn) |->
      up_ff >= rsw_pkg::PWR_CYC) else $error("reset released early");
   a_rst_min_pulse: assert property ($rose(resetn) |->
      rlo_ff >= rsw_pkg::RST_CYC) else $error("reset pulse too short");
   a_xclk_quiet: assert property (wk_ff > 0 &&
      wk_ff < rsw_pkg::WAKE_CYC - 2 |-> $stable(crystal_clock_output))
      else $error("clock output ran before wake time");
   a_xclk_starts: assert property (wk_ff == rsw_pkg::WAKE_CYC + 2 |->
      ##[0:8] $changed(crystal_clock_output))
      else $error("clock output did not start");
   a_sleep_clk_stop: assert property ($rose(power_down_pin) |->
      ##2 $stable(crystal_clock_output) [*4])
      else $error("clock output still running in sleep");
   a_sleep_holds_data: assert property (pd_ff && power_down_pin |->
      $stable(reg_rdata)) else $error("register data moved in sleep");
   a_sleep_irq_idle: assert property (pd_ff && power_down_pin |->
      irq_pin) else $error("interrupt asserted in sleep");
   a_spi_after_stable: assert property (reg_wr || reg_rd |->
      wk_ff >= rsw_pkg::STABLE_CYC + rsw_pkg::SPI_RDY_CYC - 1)
      else $error("register access before clock stable");
endmodule

// file: bench/radio_sleep_wake_sequencer_tb.sv
// Purpose: host and device joined, one full power-up and wake
// Assumes: counts unshortened, so one wake fits the run budget
// Notes:   wake irq enable can only be set after the first wake
`timescale 1ns/1ns
module radio_sleep_wake_sequencer_tb;
   logic       clk_i = 1'b0;
   logic       resetn = 1'b0;
   logic       clk_out_en = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic       wr_s = 1'b0;
   logic       rd_s = 1'b0;
   logic [7:0] rdata;
   logic       irq;
   logic       clocks_run;
   logic       osc_stable;
   logic       low_power;
   int         error_cnt = 0;
   int         num_checks = 0;
   always #20 clk_i = ~clk_i;
   rsw_link_if link ();
   rsw_device i_rsw_device (.clk_i(clk_i), .resetn_i(resetn),
      .clk_out_en_i(clk_out_en), .clocks_run_o(clocks_run),
      .osc_stable_o(osc_stable), .low_power_o(low_power), .link(link));
   rsw_host i_rsw_host (.clk_i(clk_i), .resetn_i(resetn), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata),
      .irq_o(irq), .link(link));
   rsw_link_monitor i_monitor (.clk_i(clk_i), .resetn_i(resetn),
      .resetn(link.resetn), .power_down_pin(link.power_down_pin),
      .irq_pin(link.irq_pin), .crystal_clock_output(link.crystal_clock_output),
      .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_rdata(link.reg_rdata));
   task automatic chk(input string nm, input logic [17:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr  <= a;
      wdata <= d;
      wr_s  <= 1'b1;
      @(posedge clk_i);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk_i);
      rd_s <= 1'b0;
      #1 d = rdata;
   endtask
   function automatic logic sig(input int s);
      case (s)
         0: sig = !link.power_down_pin;
         1: sig = clocks_run;
         2: sig = osc_stable;
         3: sig = irq;
         default: sig = low_power;
      endcase
   endfunction
   // bounded wait, n is cycles spent
   task automatic wait_on(input int s, input int lim, output int n);
      n = 0;
      while (sig(s) !== 1'b1 && n < lim) begin
         @(posedge clk_i);
         #1 n++;
      end
   endtask
   // fixed settle: the write path has no done flag
   task automatic dev_wr(input logic [7:0] a, d);
      wr(rsw_pkg::H_REG_ADDR, a);
      wr(rsw_pkg::H_REG_WDATA, d);
      wr(rsw_pkg::H_CTRL_ADDR, 8'h04);
      repeat (4) @(posedge clk_i);
   endtask
   task automatic dev_rd(input logic [7:0] a, output logic [7:0] d);
      logic [7:0] s;
      int         k;
      s = 8'h00;
      k = 0;
      wr(rsw_pkg::H_REG_ADDR, a);
      wr(rsw_pkg::H_CTRL_ADDR, 8'h08);
      while (s[2] !== 1'b1 && k < 20) begin
         rd(rsw_pkg::H_IRQ_ST_ADDR, s);
         k++;
      end
      chk("read done", s[2], 1'b1);
      chk("masked irq", irq, 1'b0);
      wr(rsw_pkg::H_IRQ_ST_ADDR, 8'h04);
      rd(rsw_pkg::H_REG_RDATA, d);
   endtask
   initial begin
      #(40 * 100_000);
      error_cnt++;
      report_and_stop;
   end
   initial begin
      logic [7:0] v;
      logic [7:0] r;
      logic [7:0] cfg [3];
      int         n;
      int         t;
      cfg = '{8'h02, 8'h03, 8'h00};
      void'($urandom(32'h1c8c_5ecd));
      repeat (2) @(posedge clk_i);
      resetn <= 1'b1;
      rd(rsw_pkg::H_STATUS_ADDR, v);
      chk("status pwrup", v, 8'h01);
      chk("reset held", link.resetn, 1'b0);
      chk("pd at pwrup", link.power_down_pin, 1'b1);
      chk("low power", low_power, 1'b1);
      wr(rsw_pkg::H_CTRL_ADDR, 8'h00);
      wr(rsw_pkg::H_IRQ_MSK_ADDR, 8'h01);
      wait_on(0, rsw_pkg::PWR_CYC + rsw_pkg::PD_CYC + 100, n);
      chk("pd release", n >= rsw_pkg::PWR_CYC - 10, 1'b1);
      wait_on(1, rsw_pkg::WAKE_CYC + 10, n);
      chk("clocks run", n >= rsw_pkg::WAKE_CYC - 2 &&
          n <= rsw_pkg::WAKE_CYC + 2, 1'b1);
      wait_on(2, rsw_pkg::STABLE_CYC - rsw_pkg::WAKE_CYC + 10, t);
      chk("osc stable", n + t >= rsw_pkg::STABLE_CYC - 2 &&
          n + t <= rsw_pkg::STABLE_CYC + 2, 1'b1);
      wait_on(3, 100, n);
      chk("ready gap", n >= rsw_pkg::SPI_RDY_CYC - 2, 1'b1);
      rd(rsw_pkg::H_STATUS_ADDR, v);
      chk("status ready", v, 8'h20);
      rd(rsw_pkg::H_IRQ_ST_ADDR, v);
      chk("ready event", v[0], 1'b1);
      wr(rsw_pkg::H_IRQ_ST_ADDR, 8'h01);
      rd(rsw_pkg::H_IRQ_ST_ADDR, v);
      chk("event cleared", v[0], 1'b0);
      chk("irq dropped", irq, 1'b0);
      rd(4'h9, v);
      chk("unmapped", v, 8'h00);
      dev_rd(rsw_pkg::IRQ_PIN_CONFIG_ADDR, v);
      chk("cfg reset", v, rsw_pkg::IRQ_PIN_CONFIG_RST);
      dev_rd(rsw_pkg::WAKE_IRQ_ENABLE_ADDR, v);
      chk("wake en reset", v, rsw_pkg::WAKE_IRQ_ENABLE_RST);
      repeat (3) begin
         v = 8'($urandom);
         dev_wr(rsw_pkg::WAKE_IRQ_ENABLE_ADDR, v);
         dev_rd(rsw_pkg::WAKE_IRQ_ENABLE_ADDR, r);
         chk("wake en rw", r, v);
      end
      foreach (cfg[i]) begin
         dev_wr(rsw_pkg::IRQ_PIN_CONFIG_ADDR, cfg[i]);
         chk("irq oe", link.irq_oe, cfg[i][1]);
         chk("irq idle", link.irq_pin, !(cfg[i][1] & cfg[i][0]));
      end
      wr(rsw_pkg::H_CTRL_ADDR, 8'h03);
      wait_on(4, 20, n);
      chk("sleep entry", n <= 3, 1'b1);
      rd(rsw_pkg::H_STATUS_ADDR, v);
      chk("status reset", v, 8'h02);
      chk("reset pulse", link.resetn, 1'b0);
      repeat (300) @(posedge clk_i);
      #1 chk("still asleep", low_power, 1'b1);
      chk("clocks off", clocks_run, 1'b0);
      chk("reset released", link.resetn, 1'b1);
      rd(rsw_pkg::H_STATUS_ADDR, v);
      chk("status sleep", v, 8'h04);
      report_and_stop;
   end
endmodule
